// file: rtl/fsic_pkg.sv
// package: constants, register map and carrier types of the interlock combiner
package fsic_pkg;
    // channel count and timing
    localparam int NUM_CH = 16;
    localparam int CLK_FREQ_MHZ = 100;
    localparam logic [1:0] PULSE_CYCLES = 2'h3;
    // register map, byte addresses
    localparam logic [31:0] BASE_ADDR = 32'h43c00000;
    localparam logic [7:0] OFS_ENABLE = 8'h00;
    localparam logic [7:0] OFS_RESET = 8'h04;
    localparam logic [7:0] OFS_LIVE = 8'h08;
    localparam logic [7:0] OFS_LATCHED = 8'h0c;
    localparam logic [7:0] OFS_INT_STAT = 8'h10;
    localparam logic [7:0] OFS_INT_MASK = 8'h14;
    // values after reset, and bus response codes
    localparam logic [15:0] ENABLE_RST = 16'h0000;
    localparam logic [15:0] INT_MASK_RST = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } fsic_axi_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } fsic_axi_rsp_type;

    typedef struct packed {
        logic [15:0] enable;
        logic rstCmd;
        logic [1:0] pulseCnt;
        logic userReset;
        logic [15:0] liveS1;
        logic [15:0] liveS2;
        logic [15:0] liveS3;
        logic [15:0] liveFilt;
        logic [15:0] latS1;
        logic [15:0] latS2;
        logic [15:0] latS3;
        logic [15:0] latFilt;
        logic [15:0] intStat;
        logic [15:0] intMask;
        logic awHeld;
        logic [31:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic enWritten;
    } fsic_state_type;
endpackage

// file: rtl/fsic_channel_latch.sv
// one channel failure latch: falling edge traps, user reset releases
`timescale 1ns/1ns
module fsic_channel_latch
    import fsic_pkg::*;
(
    // channel level and controls
    input wire logic chIn,
    input wire logic userReset,
    input wire logic rst_b,
    // trapped state, high means normal
    output logic latched
);
    logic releaseCond;

    // release only while the input is high again
    assign releaseCond = userReset & chIn;

    // the channel itself clocks the trap; data is always zero
    always_ff @(negedge chIn or negedge rst_b or posedge releaseCond) begin
        if (!rst_b) begin
            latched <= 1'b0;
        end else if (releaseCond) begin
            latched <= 1'b1;
        end else begin
            latched <= 1'b0;
        end
    end
endmodule

// file: rtl/fsic_combiner.sv
// interlock combiner top: fast outputs, latches, axi4-lite registers, interrupt
// What this block does
// - first output is the AND of all sixteen enable-masked channel inputs.
// - second output is the AND of the sixteen channel failure latches.
// - first output follows channel levels combinationally; the second falls with a channel, no clock in either trip path.
// - enable bit zero passes the pin; one forces the channel high.
// - all enable bits are zero after reset, every channel active.
// - a falling edge on a channel traps its latch at zero.
// - a reset command makes a user reset pulse of exactly three cycles.
// - the user reset pulse presets every latch whose input is high asynchronously to one.
// - a latch releases only while its input is high; low input keeps it zero.
// - all clocked logic except the latches, which each channel's falling edge clocks, runs from the single system clock.
// - enable, live and latched vectors are readable, one bit per channel.
// - registers sit behind an axi slave at base 0x43c00000.
// - enable 0x0, reset 0x4, live 0x8, latched 0xc from base.
// - status bit one means normal, zero means failed.
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
module fsic_combiner
    import fsic_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // channel pins, high means healthy
    input wire logic [NUM_CH-1:0] chIn,
    // shutdown outputs, low means trip
    output logic shutLive,
    output logic shutLatched,
    // register bus
    input wire fsic_axi_req_type axiReq,
    output fsic_axi_rsp_type axiRsp,
    // interrupt
    output logic irq
);
    fsic_state_type s_reg;
    fsic_state_type s_next;
    logic [NUM_CH-1:0] latched;
    logic [NUM_CH-1:0] masked;
    logic awTake;
    logic wTake;
    logic arTake;
    logic doWrite;
    logic wrHit;
    logic [7:0] wrOfs;
    logic [7:0] rdOfs;
    logic [15:0] wrVal;
    logic [15:0] fallEv;

    // fast paths: no sys_clk flop between pin and output
    assign masked = chIn | s_reg.enable;
    assign shutLive = &masked;
    assign shutLatched = &latched;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gen_ch
            // a disabled channel is held high here too, so it can never trap
            fsic_channel_latch u_latch (
                .chIn(masked[g]),
                .userReset(s_reg.userReset),
                .rst_b(rst_b),
                .latched(latched[g])
            );
        end
    endgenerate

    // handshakes
    assign awTake = axiReq.awvalid & axiRsp.awready;
    assign wTake = axiReq.wvalid & axiRsp.wready;
    assign arTake = axiReq.arvalid & axiRsp.arready;
    assign doWrite = s_reg.awHeld & s_reg.wHeld & ~s_reg.bvalid;
    assign wrOfs = s_reg.awAddr[7:0];
    assign rdOfs = axiReq.araddr[7:0];
    assign wrHit = s_reg.awAddr[31:8] == BASE_ADDR[31:8];
    assign wrVal = s_reg.wData[15:0];

    always_comb begin
        axiRsp.awready = ~s_reg.awHeld & ~s_reg.bvalid;
        axiRsp.wready = ~s_reg.wHeld & ~s_reg.bvalid;
        axiRsp.bvalid = s_reg.bvalid;
        axiRsp.bresp = s_reg.bresp;
        axiRsp.arready = ~s_reg.rvalid;
        axiRsp.rvalid = s_reg.rvalid;
        axiRsp.rdata = s_reg.rdata;
        axiRsp.rresp = s_reg.rresp;
    end

    assign irq = |(s_reg.intStat & s_reg.intMask);

    always_comb begin
        s_next = s_reg;
        // pins and latches come from outside the clock: three stages
        s_next.liveS1 = masked;
        s_next.liveS2 = s_reg.liveS1;
        s_next.liveS3 = s_reg.liveS2;
        if (s_reg.liveS2 == s_reg.liveS3) begin
            s_next.liveFilt = s_reg.liveS3;
        end
        s_next.latS1 = latched;
        s_next.latS2 = s_reg.latS1;
        s_next.latS3 = s_reg.latS2;
        if (s_reg.latS2 == s_reg.latS3) begin
            s_next.latFilt = s_reg.latS3;
        end
        // a trap seen by software raises its event bit
        fallEv = s_reg.latFilt & ~s_next.latFilt;

        // user reset pulse counter, loaded by command
        s_next.userReset = s_reg.pulseCnt != 2'h0;
        if (s_reg.pulseCnt != 2'h0) begin
            s_next.pulseCnt = s_reg.pulseCnt - 2'h1;
        end

        // write address and data accepted in either order
        if (awTake) begin
            s_next.awHeld = 1'b1;
            s_next.awAddr = axiReq.awaddr;
        end
        if (wTake) begin
            s_next.wHeld = 1'b1;
            s_next.wData = axiReq.wdata;
            s_next.wStrb = axiReq.wstrb;
        end
        if (s_reg.bvalid && axiReq.bready) begin
            s_next.bvalid = 1'b0;
        end

        if (doWrite) begin
            s_next.awHeld = 1'b0;
            s_next.wHeld = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = RESP_OKAY;
            if (!wrHit) begin
                s_next.bresp = RESP_SLVERR;
            end else if (wrOfs == OFS_ENABLE) begin
                if (s_reg.wStrb[0]) begin
                    s_next.enable[7:0] = wrVal[7:0];
                end
                if (s_reg.wStrb[1]) begin
                    s_next.enable[15:8] = wrVal[15:8];
                end
                s_next.enWritten = 1'b1;
            end else if (wrOfs == OFS_RESET) begin
                if (s_reg.wStrb[0]) begin
                    s_next.rstCmd = wrVal[0];
                    // only a fresh one starts a pulse, so a held one is harmless
                    if (wrVal[0] && !s_reg.rstCmd && s_reg.pulseCnt == 2'h0) begin
                        s_next.pulseCnt = PULSE_CYCLES;
                    end
                end
            end else if (wrOfs == OFS_LIVE || wrOfs == OFS_LATCHED) begin
                s_next.bresp = RESP_OKAY;
            end else if (wrOfs == OFS_INT_STAT) begin
                if (s_reg.wStrb[0]) begin
                    s_next.intStat[7:0] = s_reg.intStat[7:0] & ~wrVal[7:0];
                end
                if (s_reg.wStrb[1]) begin
                    s_next.intStat[15:8] = s_reg.intStat[15:8] & ~wrVal[15:8];
                end
            end else if (wrOfs == OFS_INT_MASK) begin
                if (s_reg.wStrb[0]) begin
                    s_next.intMask[7:0] = wrVal[7:0];
                end
                if (s_reg.wStrb[1]) begin
                    s_next.intMask[15:8] = wrVal[15:8];
                end
            end else begin
                s_next.bresp = RESP_SLVERR;
            end
        end
        // set wins over a clear in the same cycle
        s_next.intStat = s_next.intStat | fallEv;

        // reads answer one cycle after the address is taken
        if (s_reg.rvalid && axiReq.rready) begin
            s_next.rvalid = 1'b0;
        end
        if (arTake) begin
            s_next.rvalid = 1'b1;
            s_next.rresp = RESP_OKAY;
            s_next.rdata = 32'h0;
            if (axiReq.araddr[31:8] != BASE_ADDR[31:8]) begin
                s_next.rresp = RESP_SLVERR;
            end else if (rdOfs == OFS_ENABLE) begin
                s_next.rdata[15:0] = s_reg.enable;
            end else if (rdOfs == OFS_RESET) begin
                s_next.rdata[0] = s_reg.rstCmd;
            end else if (rdOfs == OFS_LIVE) begin
                s_next.rdata[15:0] = s_reg.liveFilt;
            end else if (rdOfs == OFS_LATCHED) begin
                s_next.rdata[15:0] = s_reg.latFilt;
            end else if (rdOfs == OFS_INT_STAT) begin
                s_next.rdata[15:0] = s_reg.intStat;
            end else if (rdOfs == OFS_INT_MASK) begin
                s_next.rdata[15:0] = s_reg.intMask;
            end else begin
                s_next.rresp = RESP_SLVERR;
            end
        end
    end

    // single system clock for all clocked state except the channel latches
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
            s_reg.enable <= ENABLE_RST;
            s_reg.intMask <= INT_MASK_RST;
            // a pulse after reset releases latches whose inputs are high
            s_reg.pulseCnt <= PULSE_CYCLES;
        end else begin
            s_reg <= s_next;
        end
    end

    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    a_live_and: assert property (shutLive == &(chIn | s_reg.enable))
        else $error("live output differs from masked AND");
    a_latch_and: assert property (shutLatched == &latched)
        else $error("latched output differs from latch AND");
    a_forced_high: assert property ((&s_reg.enable) |-> shutLive)
        else $error("fully masked channels still trip");
    a_enable_default: assert property (!s_reg.enWritten |-> s_reg.enable == 16'h0)
        else $error("enable not zero before any write");
    a_fall_trap: assert property ((($past(masked) & ~masked) & latched) == 16'h0)
        else $error("falling channel not trapped");
    a_pulse_three: assert property ($rose(s_reg.userReset) |->
        s_reg.userReset[*3] ##1 !s_reg.userReset)
        else $error("user reset pulse not three cycles");
    a_low_hold: assert property ((~$past(latched) & ~$past(masked) & ~masked & latched)
        == 16'h0)
        else $error("latch released while input low");
    a_cmd_start: assert property ((doWrite && wrHit && wrOfs == OFS_RESET
        && s_reg.wStrb[0] && wrVal[0] && !s_reg.rstCmd && s_reg.pulseCnt == 2'h0)
        |-> ##2 s_reg.userReset)
        else $error("reset command gave no pulse");
    a_read_live: assert property ((arTake && axiReq.araddr == (BASE_ADDR | 32'h8))
        |=> s_reg.rdata == {16'h0, $past(s_reg.liveFilt)})
        else $error("live status read wrong");
    a_ro_ignored: assert property ((doWrite && wrOfs == OFS_LIVE) |=>
        $stable(s_reg.enable) && $stable(s_reg.intMask))
        else $error("write to status changed state");
    a_irq_level: assert property (irq == |(s_reg.intStat & s_reg.intMask))
        else $error("interrupt level wrong");
    a_resp_after: assert property (doWrite |=> s_reg.bvalid)
        else $error("write answer missing");

    c_live_trip: cover property ($fell(shutLive));
    c_user_pulse: cover property ($rose(s_reg.userReset));
    c_trap_release: cover property ($fell(shutLatched) ##[1:200] $rose(shutLatched));
    c_irq: cover property ($rose(irq));
endmodule

// file: testbench/fsic_monitor_model.sv
// partner model: sixteen channel monitors driving healthy levels
`timescale 1ns/1ns
module fsic_monitor_model (
    // commanded levels, high means healthy
    input wire logic [15:0] healthy,
    input wire logic slowMode,
    // channel pins
    output logic [15:0] chIn
);
    // open pins rest low through the pull-downs, so they read as failed
    initial chIn = 16'h0000;
    // a slow monitor settles off the clock grid
    always @(healthy) begin
        if (slowMode) begin
            #13;
        end
        chIn = healthy;
    end
endmodule

// file: testbench/fsic_combiner_bench.sv
// self-checking bench for the interlock combiner
`timescale 1ns/1ns
module fsic_combiner_bench
    import fsic_pkg::*;
;
    logic sys_clk;
    logic rst_b;
    logic shutLive;
    logic shutLatched;
    logic irq;
    logic slowMode;
    logic [15:0] healthy;
    logic [15:0] chIn;
    logic [15:0] en;
    fsic_axi_req_type req;
    fsic_axi_rsp_type rsp;
    logic [33:0] rdQ[$];
    logic [1:0] wrQ[$];
    int miscompares;
    int checks;
    int cycles;

    fsic_monitor_model mon (.healthy(healthy), .slowMode(slowMode), .chIn(chIn));
    fsic_combiner dut (.sys_clk(sys_clk), .rst_b(rst_b), .chIn(chIn), .shutLive(shutLive),
        .shutLatched(shutLatched), .axiReq(req), .axiRsp(rsp), .irq(irq));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic cmpWord(input string what, input logic [33:0] exp, input logic [33:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmpBit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic summarize;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // starts on a fresh edge so no request signal is assigned twice in one step
    task automatic axiWrite(input logic [7:0] ofs, input logic [31:0] d, input logic [1:0] er);
        wrQ.push_back(er);
        @(posedge sys_clk);
        req.awaddr <= BASE_ADDR | {24'h0, ofs};
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!(rsp.bvalid && req.bready));
        req.bready <= 1'b0;
    endtask

    task automatic axiRead(input logic [7:0] ofs, input logic [15:0] v, input logic [1:0] er);
        rdQ.push_back({er, 16'h0000, v});
        @(posedge sys_clk);
        req.araddr <= BASE_ADDR | {24'h0, ofs};
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!(rsp.rvalid && req.rready));
        req.rready <= 1'b0;
    endtask

    task automatic waitCyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // watcher: oldest note against each bus answer, plus the hang limit
    always @(posedge sys_clk) begin
        cycles++;
        if (rsp.rvalid && req.rready) cmpWord("read", rdQ.pop_front(), {rsp.rresp, rsp.rdata});
        if (rsp.bvalid && req.bready) cmpWord("bresp", {32'h0, wrQ.pop_front()}, {32'h0, rsp.bresp});
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end

    initial begin
        rst_b = 1'b0;
        req = '0;
        // after the model is waiting, so its pins leave the pull-down level
        healthy <= 16'hffff;
        slowMode <= 1'b0;
        void'($urandom(67));
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        waitCyc(8);
        cmpBit("shutLatched", 1'b1, shutLatched);
        axiRead(OFS_ENABLE, 16'h0000, RESP_OKAY);
        axiWrite(OFS_INT_MASK, 32'h20, RESP_OKAY);
        $display("reset defaults done");
        @(posedge sys_clk);
        healthy[5] <= 1'b0;
        #2;
        cmpBit("shutLive", 1'b0, shutLive);
        cmpBit("shutLatched", 1'b0, shutLatched);
        @(posedge sys_clk);
        healthy[5] <= 1'b1;
        #2;
        cmpBit("shutLive", 1'b1, shutLive);
        cmpBit("shutLatched", 1'b0, shutLatched);
        waitCyc(8);
        cmpBit("irq", 1'b1, irq);
        axiRead(OFS_LATCHED, 16'hffdf, RESP_OKAY);
        axiRead(OFS_LIVE, 16'hffff, RESP_OKAY);
        axiWrite(OFS_INT_STAT, 32'h20, RESP_OKAY);
        waitCyc(2);
        cmpBit("irq", 1'b0, irq);
        $display("trap and interrupt done");
        // slow monitor holds channel 3 low across a reset command
        @(posedge sys_clk);
        slowMode <= 1'b1;
        healthy[3] <= 1'b0;
        waitCyc(4);
        cmpBit("shutLive", 1'b0, shutLive);
        axiWrite(OFS_ENABLE, 32'h8, RESP_OKAY);
        cmpBit("shutLive", 1'b1, shutLive);
        axiWrite(OFS_ENABLE, 32'h0, RESP_OKAY);
        cmpBit("shutLive", 1'b0, shutLive);
        axiWrite(OFS_RESET, 32'h1, RESP_OKAY);
        axiWrite(OFS_RESET, 32'h0, RESP_OKAY);
        waitCyc(6);
        cmpBit("shutLatched", 1'b0, shutLatched);
        axiRead(OFS_LATCHED, 16'hfff7, RESP_OKAY);
        axiRead(OFS_INT_STAT, 16'h0008, RESP_OKAY);
        cmpBit("irq", 1'b0, irq);
        healthy[3] <= 1'b1;
        slowMode <= 1'b0;
        waitCyc(4);
        cmpBit("shutLatched", 1'b0, shutLatched);
        axiWrite(OFS_RESET, 32'h1, RESP_OKAY);
        axiWrite(OFS_RESET, 32'h0, RESP_OKAY);
        waitCyc(6);
        cmpBit("shutLatched", 1'b1, shutLatched);
        $display("user reset done");
        axiWrite(OFS_LIVE, 32'h0, RESP_OKAY);
        axiWrite(OFS_LATCHED, 32'h0, RESP_OKAY);
        axiRead(OFS_LATCHED, 16'hffff, RESP_OKAY);
        axiWrite(8'h20, 32'h0, RESP_SLVERR);
        $display("read-only and unmapped done");
        en = 16'($urandom());
        axiWrite(OFS_ENABLE, {16'h0, en}, RESP_OKAY);
        axiRead(OFS_ENABLE, en, RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            healthy <= 16'($urandom());
            #2;
            cmpBit("shutLive", &(healthy | en), shutLive);
        end
        // every channel disabled: low pins neither trip nor hold a latch
        axiWrite(OFS_ENABLE, 32'hffff, RESP_OKAY);
        @(posedge sys_clk);
        healthy <= 16'h0000;
        #2;
        cmpBit("shutLive", 1'b1, shutLive);
        axiWrite(OFS_RESET, 32'h1, RESP_OKAY);
        axiWrite(OFS_RESET, 32'h0, RESP_OKAY);
        waitCyc(6);
        cmpBit("shutLatched", 1'b1, shutLatched);
        $display("random masking done");
        summarize();
    end
endmodule
